// ==== logic/tec_map.vh ====
`ifndef TEC_MAP_VH
`define TEC_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_SETPOINT 8'h00
`define OFF_POS_ILIM 8'h04
`define OFF_NEG_ILIM 8'h08
`define OFF_POS_VTH 8'h0C
`define OFF_NEG_VTH 8'h10
`define OFF_FF_GAIN 8'h14
`define OFF_CONFIG 8'h18
`define OFF_STATUS 8'h1C
`define OFF_CMD 8'h20
`define OFF_DRIVE 8'h24

// ----------------------------------------
// Reset values of the settings
// ----------------------------------------
`define RST_SETPOINT 16'h0000
`define RST_POS_ILIM 16'h03E8
`define RST_NEG_ILIM 16'hFC18
`define RST_POS_VTH 16'h1388
`define RST_NEG_VTH 16'hEC78
`define RST_FF_GAIN 16'h0000
`define RST_CONFIG 8'hC1

// ----------------------------------------
// Allowed ranges and spans
// ----------------------------------------
`define MIN_SETPOINT 32'hFFFFFC18
`define MAX_SETPOINT 32'h000003E8
`define MIN_POS_ILIM 32'h00000000
`define MAX_POS_ILIM 32'h000003E8
`define MIN_NEG_ILIM 32'hFFFFFC18
`define MAX_NEG_ILIM 32'h00000000
`define MIN_POS_VTH 32'h00000000
`define MAX_POS_VTH 32'h00001388
`define MIN_NEG_VTH 32'hFFFFEC78
`define MAX_NEG_VTH 32'h00000000
`define SPAN_CURRENT 16'h07D0
`define SPAN_ILIM 16'h03E8
`define SPAN_VTH 16'h1388
`define CODE_FULL 32'h00000FFF
`define GAIN_UNITY 32'sh000003E8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_MAN 0
`define CFG_EXT 1
`define CFG_FF 2
`define CFG_OUT 3
`define CFG_ITRIP_LO 4
`define CFG_VTRIP_LO 6
`define ST_POS_LIM 0
`define ST_NEG_LIM 1
`define ST_POS_OV 2
`define ST_NEG_OV 3
`define ST_EXEC_ERR 4
`define ST_TRIPPED 8
`define ST_SOURCE_ON 9
`define CMD_SAVE 0
`define CMD_RECALL 1
`define CMD_DEFAULTS 2
`define CMD_CLEAR_TRIP 3

// ----------------------------------------
// Saved copy layout
// ----------------------------------------
`define NV_LAST 3'h6
`define NV_CONFIG 3'h6

`endif

// ==== logic/nv_store.v ====
`timescale 1ns/1ps
`default_nettype none

// Saved copy of the settings; the array has no reset so a soft reset keeps it
module nv_store (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire we,
  input wire [2:0] waddr,
  input wire [15:0] wdata,
  input wire [2:0] raddr,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:7];

  // Write port
  always @(posedge pclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule // nv_store

`default_nettype wire

// ==== logic/tec_drive_setting_params.v ====
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tec_map.vh"

// Function
// RULE1: signed setpoint, -1000..1000 mA, 12-bit, readable
// RULE2: power-on reloads saved copy; command loads defaults
// RULE3: positive limit 0..1000 mA, default 1000
// RULE4: demand above positive limit is clamped
// RULE5: negative limit -1000..0 mA, default -1000
// RULE6: demand below negative limit is clamped
// RULE7: positive threshold 0..5000 mV, default 5000
// RULE8: voltage above positive threshold sets flag
// RULE9: negative threshold -5000..0 mV, default -5000
// RULE10: voltage below negative threshold sets flag
// RULE11: current limiting may trip source off
// RULE12: over-voltage detection may trip source off
// RULE13: feedforward gain -1000..1000 per mille, default 0
// RULE14: manual enable bit, default 1
// RULE15: host programs setpoint before enabling output
// RULE16: external control enable bit
// RULE17: feedforward control enable bit
// RULE18: current trip select 0..3 meaning
// RULE19: voltage trip select 0..3, default 3
// RULE20: out-of-range write rejected, error recorded
// RULE21: settings scaled to 12-bit analog codes
module tec_drive_setting_params (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] meas_voltage,
  input wire [15:0] ext_current,
  input wire [15:0] feedforward_input,
  output reg [11:0] setpoint_code,
  output reg [11:0] pos_limit_code,
  output reg [11:0] neg_limit_code,
  output reg [11:0] pos_threshold_code,
  output reg [11:0] neg_threshold_code,
  output reg [11:0] gain_code,
  output reg [15:0] drive_current,
  output reg manual_control_enable,
  output reg external_control_enable,
  output reg feedforward_enable,
  output reg source_on,
  output reg trip_active
);

  // ----------------------------------------
  // Types and helpers
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_LOAD = 2'd1;
  localparam ST_SAVE = 2'd2;

  // Signed range check of a written word
  function in_range;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
    end
  endfunction

  // Scale a setting across its full range onto 0..4095
  function [11:0] to_code;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] span;
    reg [31:0] off;
    reg [31:0] prod;
    begin
      off = {{16{v[15]}}, v} - {{16{lo[15]}}, lo};
      prod = off * `CODE_FULL;
      prod = prod / {16'h0000, span};
      to_code = prod[11:0];
    end
  endfunction

  // Address decode for the error answer; the read mux decodes with its own case
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a[1:0] == 2'b00) && (a <= `OFF_DRIVE);
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [15:0] setpoint_current_cmd;
  reg [15:0] pos_current_limit;
  reg [15:0] neg_current_limit;
  reg [15:0] pos_voltage_threshold;
  reg [15:0] neg_voltage_threshold;
  reg [15:0] feedforward_gain;
  reg output_enable;
  reg [1:0] current_trip_select;
  reg [1:0] voltage_trip_select;
  reg [4:0] overload_status;
  reg tripped;
  reg [1:0] state;
  reg [2:0] nv_idx;
  reg [2:0] ld_idx;
  reg ld_valid;
  reg [47:0] pin_meta;
  reg [47:0] pin_sync;
  reg [15:0] save_word;
  reg [31:0] rd_mux;
  reg [4:0] status_set;
  reg wr_ok;
  wire [15:0] nv_rdata;
  wire busy;
  wire apb_wr;
  wire apb_setup_done;
  wire [7:0] cfg_word;
  wire [15:0] meas_s;
  wire [15:0] ext_s;
  wire [15:0] ffin_s;
  wire [31:0] ff_prod;
  wire [31:0] ff_term;
  wire [17:0] demand;
  wire [17:0] pos_lim_ext;
  wire [17:0] neg_lim_ext;
  wire pos_lim_evt;
  wire neg_lim_evt;
  wire pos_ov_evt;
  wire neg_ov_evt;
  wire trip_evt;
  wire cmd_wr;
  wire do_save;
  wire do_recall;
  wire do_defaults;
  wire do_clear_trip;

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  // One wait state: pready rises on the second access cycle
  assign apb_setup_done = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite;
  assign busy = (state != ST_IDLE) || ld_valid;
  assign cmd_wr = apb_wr && (paddr == `OFF_CMD);
  assign do_save = cmd_wr && pwdata[`CMD_SAVE] && !busy;
  assign do_recall = cmd_wr && pwdata[`CMD_RECALL] && !busy;
  assign do_defaults = cmd_wr && pwdata[`CMD_DEFAULTS] && !busy;
  assign do_clear_trip = cmd_wr && pwdata[`CMD_CLEAR_TRIP];

  assign cfg_word = {voltage_trip_select, current_trip_select, output_enable,
                     feedforward_enable, external_control_enable, manual_control_enable};

  // Read mux
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `OFF_SETPOINT: rd_mux = {{16{setpoint_current_cmd[15]}}, setpoint_current_cmd}; // RULE1
      `OFF_POS_ILIM: rd_mux = {{16{pos_current_limit[15]}}, pos_current_limit};
      `OFF_NEG_ILIM: rd_mux = {{16{neg_current_limit[15]}}, neg_current_limit};
      `OFF_POS_VTH: rd_mux = {{16{pos_voltage_threshold[15]}}, pos_voltage_threshold};
      `OFF_NEG_VTH: rd_mux = {{16{neg_voltage_threshold[15]}}, neg_voltage_threshold};
      `OFF_FF_GAIN: rd_mux = {{16{feedforward_gain[15]}}, feedforward_gain};
      `OFF_CONFIG: rd_mux = {24'h000000, cfg_word};
      `OFF_STATUS: rd_mux = {22'h000000, source_on, tripped, 3'h0, overload_status};
      `OFF_DRIVE: rd_mux = {{16{drive_current[15]}}, drive_current};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Answer registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= apb_setup_done;
      if (apb_setup_done) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= !is_mapped(paddr);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Write acceptance
  // ----------------------------------------
  // Range check per register; a rejected word leaves the setting as it was
  always @* begin
    wr_ok = 1'b0;
    case (paddr)
      `OFF_SETPOINT: wr_ok = in_range(pwdata, `MIN_SETPOINT, `MAX_SETPOINT); // RULE20
      `OFF_POS_ILIM: wr_ok = in_range(pwdata, `MIN_POS_ILIM, `MAX_POS_ILIM); // RULE20
      `OFF_NEG_ILIM: wr_ok = in_range(pwdata, `MIN_NEG_ILIM, `MAX_NEG_ILIM); // RULE20
      `OFF_POS_VTH: wr_ok = in_range(pwdata, `MIN_POS_VTH, `MAX_POS_VTH); // RULE20
      `OFF_NEG_VTH: wr_ok = in_range(pwdata, `MIN_NEG_VTH, `MAX_NEG_VTH); // RULE20
      `OFF_FF_GAIN: wr_ok = in_range(pwdata, `MIN_SETPOINT, `MAX_SETPOINT); // RULE20
      `OFF_CONFIG: wr_ok = (pwdata[31:8] == 24'h000000); // RULE20
      default: wr_ok = 1'b0;
    endcase
  end

  // Settings: defaults command beats reload beats bus write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setpoint_current_cmd <= `RST_SETPOINT;
      pos_current_limit <= `RST_POS_ILIM; // RULE3
      neg_current_limit <= `RST_NEG_ILIM; // RULE5
      pos_voltage_threshold <= `RST_POS_VTH; // RULE7
      neg_voltage_threshold <= `RST_NEG_VTH; // RULE9
      feedforward_gain <= `RST_FF_GAIN; // RULE13
      {voltage_trip_select, current_trip_select, output_enable,
       feedforward_enable, external_control_enable, manual_control_enable} <= `RST_CONFIG;
    end else if (ce) begin
      if (do_defaults) begin
        setpoint_current_cmd <= `RST_SETPOINT; // RULE2
        pos_current_limit <= `RST_POS_ILIM; // RULE3
        neg_current_limit <= `RST_NEG_ILIM; // RULE5
        pos_voltage_threshold <= `RST_POS_VTH; // RULE7
        neg_voltage_threshold <= `RST_NEG_VTH; // RULE9
        feedforward_gain <= `RST_FF_GAIN; // RULE13
        {voltage_trip_select, current_trip_select, output_enable, feedforward_enable,
         external_control_enable, manual_control_enable} <= `RST_CONFIG; // RULE14 RULE19
      end else if (ld_valid) begin
        case (ld_idx) // RULE2
          3'h0: setpoint_current_cmd <= nv_rdata;
          3'h1: pos_current_limit <= nv_rdata;
          3'h2: neg_current_limit <= nv_rdata;
          3'h3: pos_voltage_threshold <= nv_rdata;
          3'h4: neg_voltage_threshold <= nv_rdata;
          3'h5: feedforward_gain <= nv_rdata;
          default: {voltage_trip_select, current_trip_select, output_enable, feedforward_enable,
                    external_control_enable, manual_control_enable} <= nv_rdata[7:0];
        endcase
      end else if (apb_wr && wr_ok && !busy) begin
        case (paddr)
          `OFF_SETPOINT: setpoint_current_cmd <= pwdata[15:0]; // RULE1
          `OFF_POS_ILIM: pos_current_limit <= pwdata[15:0]; // RULE3
          `OFF_NEG_ILIM: neg_current_limit <= pwdata[15:0]; // RULE5
          `OFF_POS_VTH: pos_voltage_threshold <= pwdata[15:0]; // RULE7
          `OFF_NEG_VTH: neg_voltage_threshold <= pwdata[15:0]; // RULE9
          `OFF_FF_GAIN: feedforward_gain <= pwdata[15:0]; // RULE13
          default: begin
            manual_control_enable <= pwdata[`CFG_MAN]; // RULE14
            external_control_enable <= pwdata[`CFG_EXT]; // RULE16
            feedforward_enable <= pwdata[`CFG_FF]; // RULE17
            output_enable <= pwdata[`CFG_OUT];
            current_trip_select <= pwdata[`CFG_ITRIP_LO+1:`CFG_ITRIP_LO]; // RULE18
            voltage_trip_select <= pwdata[`CFG_VTRIP_LO+1:`CFG_VTRIP_LO]; // RULE19
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Saved copy sequencer
  // ----------------------------------------
  // Word to store for the current index
  always @* begin
    case (nv_idx)
      3'h0: save_word = setpoint_current_cmd;
      3'h1: save_word = pos_current_limit;
      3'h2: save_word = neg_current_limit;
      3'h3: save_word = pos_voltage_threshold;
      3'h4: save_word = neg_voltage_threshold;
      3'h5: save_word = feedforward_gain;
      default: save_word = {8'h00, cfg_word};
    endcase
  end

  // Reset enters the reload walk, so power-on restores the saved copy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_LOAD; // RULE2
      nv_idx <= 3'h0;
      ld_idx <= 3'h0;
      ld_valid <= 1'b0;
    end else if (ce) begin
      ld_valid <= (state == ST_LOAD);
      ld_idx <= nv_idx;
      case (state)
        ST_IDLE: begin
          nv_idx <= 3'h0;
          if (do_recall) begin
            state <= ST_LOAD;
          end else if (do_save) begin
            state <= ST_SAVE;
          end
        end
        ST_LOAD, ST_SAVE: begin
          nv_idx <= nv_idx + 3'h1;
          if (nv_idx == `NV_LAST) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  nv_store u_nv_store (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .we(state == ST_SAVE),
    .waddr(nv_idx),
    .wdata(save_word),
    .raddr(nv_idx),
    .rdata(nv_rdata)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Words from the converters are assumed stable for several cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 48'h000000000000;
      pin_sync <= 48'h000000000000;
    end else if (ce) begin
      pin_meta <= {meas_voltage, ext_current, feedforward_input};
      pin_sync <= pin_meta;
    end
  end
  assign meas_s = pin_sync[47:32];
  assign ext_s = pin_sync[31:16];
  assign ffin_s = pin_sync[15:0];

  // ----------------------------------------
  // Current demand and limiting
  // ----------------------------------------
  assign ff_prod = $signed(ffin_s) * $signed(feedforward_gain); // RULE13
  assign ff_term = $signed(ff_prod) / `GAIN_UNITY;
  assign demand = (manual_control_enable ? {{2{setpoint_current_cmd[15]}},
                    setpoint_current_cmd} : 18'h00000) // RULE14
                + (external_control_enable ? {{2{ext_s[15]}}, ext_s} : 18'h00000) // RULE16
                + (feedforward_enable ? ff_term[17:0] : 18'h00000); // RULE17
  assign pos_lim_ext = {{2{pos_current_limit[15]}}, pos_current_limit};
  assign neg_lim_ext = {{2{neg_current_limit[15]}}, neg_current_limit};
  assign pos_lim_evt = $signed(demand) > $signed(pos_lim_ext); // RULE4
  assign neg_lim_evt = $signed(demand) < $signed(neg_lim_ext); // RULE6
  assign pos_ov_evt = $signed(meas_s) > $signed(pos_voltage_threshold); // RULE8
  assign neg_ov_evt = $signed(meas_s) < $signed(neg_voltage_threshold); // RULE10

  // Clamp whatever mix of inputs is active
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_current <= 16'h0000;
    end else if (ce) begin
      if (pos_lim_evt) begin
        drive_current <= pos_current_limit; // RULE4
      end else if (neg_lim_evt) begin
        drive_current <= neg_current_limit; // RULE6
      end else begin
        drive_current <= demand[15:0];
      end
    end
  end

  // ----------------------------------------
  // Overload flags and trip
  // ----------------------------------------
  always @* begin
    status_set = 5'h00;
    status_set[`ST_POS_LIM] = pos_lim_evt;
    status_set[`ST_NEG_LIM] = neg_lim_evt;
    status_set[`ST_POS_OV] = pos_ov_evt; // RULE8
    status_set[`ST_NEG_OV] = neg_ov_evt; // RULE10
    status_set[`ST_EXEC_ERR] = apb_wr && !busy && (paddr <= `OFF_CONFIG) && !wr_ok; // RULE20
  end

  assign trip_evt = (current_trip_select[0] && pos_lim_evt)
                  || (current_trip_select[1] && neg_lim_evt) // RULE11 RULE18
                  || (voltage_trip_select[0] && pos_ov_evt)
                  || (voltage_trip_select[1] && neg_ov_evt); // RULE12 RULE19

  // Sticky flags clear by writing ones; a new event wins over the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overload_status <= 5'h00;
      tripped <= 1'b0;
      source_on <= 1'b0;
      trip_active <= 1'b0;
    end else if (ce) begin
      if (apb_wr && paddr == `OFF_STATUS) begin
        overload_status <= (overload_status & ~pwdata[4:0]) | status_set;
      end else begin
        overload_status <= overload_status | status_set;
      end
      if (trip_evt) begin
        tripped <= 1'b1; // RULE11 RULE12
      end else if (do_clear_trip) begin
        tripped <= 1'b0;
      end
      trip_active <= tripped || trip_evt;
      source_on <= output_enable && !tripped && !trip_evt; // RULE11 RULE12
    end
  end

  // ----------------------------------------
  // Analog stage codes
  // ----------------------------------------
  // Divides are by constants and fold into fixed multipliers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setpoint_code <= 12'h000;
      pos_limit_code <= 12'h000;
      neg_limit_code <= 12'h000;
      pos_threshold_code <= 12'h000;
      neg_threshold_code <= 12'h000;
      gain_code <= 12'h000;
    end else if (ce) begin
      setpoint_code <= to_code(setpoint_current_cmd, 16'hFC18, `SPAN_CURRENT); // RULE21 RULE1
      pos_limit_code <= to_code(pos_current_limit, 16'h0000, `SPAN_ILIM); // RULE21
      neg_limit_code <= to_code(neg_current_limit, 16'hFC18, `SPAN_ILIM); // RULE21
      pos_threshold_code <= to_code(pos_voltage_threshold, 16'h0000, `SPAN_VTH); // RULE21
      neg_threshold_code <= to_code(neg_voltage_threshold, 16'hEC78, `SPAN_VTH); // RULE21
      gain_code <= to_code(feedforward_gain, 16'hFC18, `SPAN_CURRENT); // RULE21
    end
  end

endmodule // tec_drive_setting_params

`default_nettype wire

// ==== verification/tec_params_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module tec_params_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic [15:0] drive_current,
  input wire logic [11:0] pos_limit_code,
  input wire logic [11:0] neg_limit_code,
  input wire logic manual_control_enable,
  input wire logic external_control_enable,
  input wire logic feedforward_enable,
  input wire logic source_on,
  input wire logic trip_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // One wait state, then a single-cycle answer
  ready_wait_a: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  // ----------------------------------------
  // Output current
  // ----------------------------------------
  // Code is truncated, so the bound is strict; settle time allowed after a change
  pos_clamp_a: assert property ($stable(pos_limit_code) &&
    pos_limit_code == $past(pos_limit_code, 3) |->
    $signed(drive_current) * 4095 < ($signed({1'b0, pos_limit_code}) + 1) * 1000)
    else $error("above positive limit");
  neg_clamp_a: assert property ($stable(neg_limit_code) &&
    neg_limit_code == $past(neg_limit_code, 3) |->
    ($signed(drive_current) + 1000) * 4095 >= $signed({1'b0, neg_limit_code}) * 1000)
    else $error("below negative limit");
  idle_drive_a: assert property ((!manual_control_enable && !external_control_enable &&
    !feedforward_enable) [*3] |-> drive_current == 16'h0000)
    else $error("drive with no path enabled");
  // ----------------------------------------
  // Trip and enables
  // ----------------------------------------
  trip_off_a: assert property (trip_active |-> !source_on)
    else $error("source on while tripped");
  reset_enable_a: assert property ($rose(presetn) |->
    manual_control_enable && !external_control_enable && !feedforward_enable)
    else $error("enable reset values wrong");
endmodule // tec_params_monitor

bind tec_drive_setting_params tec_params_monitor i_tec_params_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .drive_current(drive_current),
  .pos_limit_code(pos_limit_code), .neg_limit_code(neg_limit_code),
  .manual_control_enable(manual_control_enable),
  .external_control_enable(external_control_enable),
  .feedforward_enable(feedforward_enable), .source_on(source_on),
  .trip_active(trip_active));
`default_nettype wire

// ==== verification/tec_load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tec_load_model (
  input wire logic pclk,
  input wire logic [15:0] drive_current,
  input wire logic source_on,
  input wire logic [15:0] v_bias,
  output var logic [15:0] meas_voltage = 16'h0000
);
  // One ohm load plus offset; relay shorts the load while the source is off
  always @(posedge pclk) begin
    meas_voltage <= v_bias + (source_on ? drive_current : 16'h0000);
  end
endmodule // tec_load_model
`default_nettype wire

// ==== verification/tec_drive_setting_params_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tec_map.vh"
module tec_drive_setting_params_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic source_on, trip_active, man_en, ext_en, ff_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] meas_voltage, ext_current, feedforward_input, v_bias, drive_current;
  logic [11:0] sp_c, pl_c, nl_c, pt_c, nt_c, g_c;
  logic [31:0] dv [7] = '{32'h0, 32'h3E8, 32'hFFFFFC18, 32'h1388, 32'hFFFFEC78, 32'h0, 32'hC1};
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int i;
  // ----------------------------------------
  // Clock, watchdog, parts
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Whole run needs about 420 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  tec_drive_setting_params i_tec_drive_setting_params (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_voltage(meas_voltage), .ext_current(ext_current),
    .feedforward_input(feedforward_input), .setpoint_code(sp_c), .pos_limit_code(pl_c),
    .neg_limit_code(nl_c), .pos_threshold_code(pt_c), .neg_threshold_code(nt_c),
    .gain_code(g_c), .drive_current(drive_current), .manual_control_enable(man_en),
    .external_control_enable(ext_en), .feedforward_enable(ff_en), .source_on(source_on),
    .trip_active(trip_active));
  tec_load_model i_tec_load_model (.pclk(pclk), .drive_current(drive_current),
    .source_on(source_on), .v_bias(v_bias), .meas_voltage(meas_voltage));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task summarize;
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Reload after release keeps writes busy, so wait it out
  task rst;
    tk(20);
    presetn <= 1'b0;
    tk(16);
    presetn <= 1'b1;
    tk(20);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_current, feedforward_input, v_bias} = '0;
    // Saved copy starts unknown: fill it with defaults first
    tk(16);
    presetn <= 1'b1;
    tk(20);
    wr(`OFF_CMD, 32'h4);
    wr(`OFF_CMD, 32'h1);
    rst();
    for (i = 0; i < 7; i++)
      rdc(8'(i * 4), 32'hFFFFFFFF, dv[i]);
    chk({8'h0, sp_c, pl_c}, 32'h007FFFFF);
    chk({8'h0, nl_c, pt_c}, 32'h00000FFF);
    chk({8'h0, nt_c, g_c}, 32'h000007FF);
    wr(`OFF_SETPOINT, 32'h1F4);
    wr(`OFF_CMD, 32'h1);
    tk(10);
    wr(`OFF_SETPOINT, 32'h12C);
    rst();
    rdc(`OFF_SETPOINT, 32'hFFFFFFFF, 32'h1F4);
    wr(`OFF_CMD, 32'h4);
    rdc(`OFF_SETPOINT, 32'hFFFFFFFF, 32'h0);
    // Recall brings back the saved setpoint; wait out the walk
    wr(`OFF_CMD, 32'h2);
    tk(10);
    rdc(`OFF_SETPOINT, 32'hFFFFFFFF, 32'h1F4);
    wr(`OFF_SETPOINT, 32'h3E9);
    rdc(`OFF_SETPOINT, 32'hFFFFFFFF, 32'h1F4);
    wr(`OFF_POS_ILIM, 32'hFFFFFFFF);
    rdc(`OFF_POS_ILIM, 32'hFFFFFFFF, 32'h3E8);
    rdc(`OFF_STATUS, 32'h10, 32'h10);
    wr(`OFF_STATUS, 32'h10);
    rdc(`OFF_STATUS, 32'h10, 32'h0);
    rdc(8'h28, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Setpoint programmed before the output is enabled
    wr(`OFF_POS_ILIM, 32'h1F4);
    wr(`OFF_SETPOINT, 32'h320);
    wr(`OFF_CONFIG, 32'h19);
    tk(5);
    chk({14'h0, trip_active, source_on, drive_current}, 32'h201F4);
    chk({8'h0, sp_c, pl_c}, 32'h00E657FF);
    rdc(`OFF_STATUS, 32'h301, 32'h101);
    wr(`OFF_SETPOINT, 32'h0);
    wr(`OFF_CMD, 32'h8);
    tk(3);
    chk({31'h0, source_on}, 32'h1);
    wr(`OFF_NEG_ILIM, 32'hFFFFFE70);
    wr(`OFF_SETPOINT, 32'hFFFFFC7C);
    wr(`OFF_CONFIG, 32'h29);
    tk(5);
    chk({3'h0, source_on, nl_c, drive_current}, 32'h0999FE70);
    rdc(`OFF_STATUS, 32'h302, 32'h102);
    wr(`OFF_CONFIG, 32'h09);
    wr(`OFF_CMD, 32'h8);
    tk(5);
    chk({15'h0, source_on, drive_current}, 32'h1FE70);
    wr(`OFF_SETPOINT, 32'h0);
    wr(`OFF_POS_VTH, 32'h9C4);
    wr(`OFF_NEG_VTH, 32'hFFFFF63C);
    v_bias <= 16'hF448;
    tk(6);
    rdc(`OFF_STATUS, 32'h208, 32'h208);
    // Negative level gone before both trips arm, so only the positive one trips
    v_bias <= 16'h0BB8;
    wr(`OFF_CONFIG, 32'hC9);
    tk(6);
    rdc(`OFF_STATUS, 32'h304, 32'h104);
    v_bias <= 16'h0000;
    tk(4);
    wr(`OFF_CMD, 32'h8);
    ext_current <= 16'h0064;
    feedforward_input <= 16'h00C8;
    wr(`OFF_CONFIG, 32'h0A);
    tk(5);
    chk({13'h0, man_en, ext_en, ff_en, drive_current}, 32'h20064);
    wr(`OFF_FF_GAIN, 32'h1F4);
    wr(`OFF_CONFIG, 32'h0C);
    tk(5);
    chk({13'h0, man_en, ext_en, ff_en, drive_current}, 32'h10064);
    wr(`OFF_FF_GAIN, 32'hFFFFFC18);
    tk(5);
    chk({4'h0, g_c, drive_current}, 32'h0000FF38);
    wr(`OFF_CONFIG, 32'h08);
    tk(5);
    chk({16'h0, drive_current}, 32'h0);
    summarize();
  end
endmodule // tec_drive_setting_params_tb
`default_nettype wire
